//--- shared/eq_pkg.sv
// constants for the trim and filter preset controller
// assumes a 32-bit avalon-mm slave at byte addresses
package eq_pkg;
  // band layout
  localparam int GW = 8;
  localparam int NCH = 3;
  localparam int NBAND = 10;
  localparam int NG = NCH * NBAND;
  localparam int GAIN_MAX = 120;
  localparam int GAIN_MIN = -120;
  // presets
  localparam int TRIM_PRESETS = 10;
  localparam int FILT_PRESETS = 5;
  localparam int FILT_PER_PRESET = 6;
  localparam int FILT_SET_WORDS = FILT_PER_PRESET * NCH;
  localparam int FILT_WORDS = FILT_PRESETS * FILT_SET_WORDS;
  // bus
  localparam int ADDR_W = 9;
  localparam int WIDX_W = ADDR_W - 2;
  // word indexes (byte address = 4 * index)
  localparam logic [WIDX_W-1:0] IDX_GAIN_IN = 7'h00;
  localparam logic [WIDX_W-1:0] IDX_GAIN_FB = 7'h20;
  localparam logic [WIDX_W-1:0] IDX_TRIM_SEL = 7'h40;
  localparam logic [WIDX_W-1:0] IDX_FILT_SEL = 7'h41;
  localparam logic [WIDX_W-1:0] IDX_STROBE = 7'h42;
  localparam logic [WIDX_W-1:0] IDX_STATUS = 7'h43;
  localparam logic [WIDX_W-1:0] IDX_CFG_ADDR = 7'h44;
  localparam logic [WIDX_W-1:0] IDX_CFG_DATA = 7'h45;
  // strobe register bits
  localparam int SB_SAVE_TRIM = 0;
  localparam int SB_RECALL_TRIM = 1;
  localparam int SB_RECALL_FILT = 2;
  // status bits
  localparam int ST_FILT_LSB = 0;
  localparam int ST_CONFLICT = 4;
  // filter word fields
  localparam int FF_FREQ_LSB = 0;
  localparam int FF_GAIN_LSB = 16;
  localparam int FF_BW_LSB = 24;
  localparam int FF_TYPE_LSB = 29;
  // filter type codes
  localparam logic [2:0] FT_EQ = 3'h1;
  localparam logic [2:0] FT_HIGH_PASS = 3'h2;
  localparam logic [2:0] FT_LOW_PASS = 3'h3;
  localparam logic [2:0] FT_TREBLE_SHELF = 3'h4;
  localparam logic [2:0] FT_BASS_SHELF = 3'h5;
  // reset values
  localparam logic [31:0] SEL_RST = 32'h0000_0000;
  localparam logic [2:0] STROBE_RST = 3'h0;
endpackage : eq_pkg

//--- verilog/gain_clip.sv
// saturating gain limiter for one written band value
// assumes a signed 32-bit input from the register bus
`timescale 1ns/1ns
`default_nettype none
module gain_clip #(
  parameter int IN_W = 32,
  parameter int OUT_W = 8,
  parameter int LIM_HI = 120,
  parameter int LIM_LO = -120
) (
  // value in
  input wire logic [IN_W-1:0] raw,
  // value out
  output logic [OUT_W-1:0] clipped
);
  wire logic signed [IN_W-1:0] sraw = $signed(raw);
  wire logic over = sraw > $signed(IN_W'(LIM_HI));
  wire logic under = sraw < $signed(IN_W'(LIM_LO));
  // saturate, never reject
  assign clipped = over ? OUT_W'(LIM_HI) : (under ? OUT_W'(LIM_LO) : raw[OUT_W-1:0]);
endmodule : gain_clip
`default_nettype wire

//--- verilog/eq_trim_filter_preset_ctrl.sv
// trim band gains, trim presets and filter presets behind an avalon-mm slave
// assumes the control program owns the bus and keeps save/recall exclusive
`timescale 1ns/1ns
`default_nettype none
module eq_trim_filter_preset_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [eq_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // applied band gains, band 1 in the low byte
  output logic [eq_pkg::NBAND*eq_pkg::GW-1:0] left_band_gain_fb,
  output logic [eq_pkg::NBAND*eq_pkg::GW-1:0] right_band_gain_fb,
  output logic [eq_pkg::NBAND*eq_pkg::GW-1:0] speech_band_gain_fb,
  // applied filter read port
  input wire logic [4:0] filt_idx,
  output logic [31:0] filt_word,
  output logic [2:0] filt_preset
);
  import eq_pkg::*;

  // reset release
  logic [1:0] rst_sync_q;
  wire logic rst_n = rst_sync_q[1];
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  // state
  logic waitrequest_q;
  logic [31:0] readdata_q;
  logic [NG*GW-1:0] gain_in_q;
  logic [NG*GW-1:0] gain_app_q;
  logic [NG*GW-1:0] trim_mem [0:TRIM_PRESETS-1];
  logic [31:0] filt_mem [0:FILT_WORDS-1];
  logic [31:0] trim_sel_q;
  logic [31:0] filt_sel_q;
  logic [2:0] strobe_q;
  logic rtrim_prev_q;
  logic rfilt_prev_q;
  logic [2:0] filt_app_q;
  logic [6:0] cfg_addr_q;
  logic [31:0] filt_word_q;

  // bus decode
  wire logic [WIDX_W-1:0] widx = avs_address[ADDR_W-1:2];
  wire logic req_take = (avs_read | avs_write) & waitrequest_q;
  wire logic wr_go = avs_write & ~waitrequest_q & (avs_byteenable == 4'hF);
  wire logic in_gain = (widx >= IDX_GAIN_IN) && (widx < IDX_GAIN_IN + WIDX_W'(NG));
  wire logic in_fb = (widx >= IDX_GAIN_FB) && (widx < IDX_GAIN_FB + WIDX_W'(NG));
  wire logic [4:0] gidx = 5'(widx - IDX_GAIN_IN);
  wire logic [4:0] fbidx = 5'(widx - IDX_GAIN_FB);
  wire logic gain_wr = wr_go & in_gain;
  wire logic [GW-1:0] gain_clip_val;

  gain_clip #(
    .IN_W(32),
    .OUT_W(GW),
    .LIM_HI(GAIN_MAX),
    .LIM_LO(GAIN_MIN)
  ) u_clip (
    .raw(avs_writedata),
    .clipped(gain_clip_val)
  );

  // strobe arbitration
  wire logic s_save = strobe_q[SB_SAVE_TRIM];
  wire logic s_rtrim = strobe_q[SB_RECALL_TRIM];
  wire logic s_rfilt = strobe_q[SB_RECALL_FILT];
  wire logic conflict = (s_save & s_rtrim) | (s_save & s_rfilt) | (s_rtrim & s_rfilt);
  wire logic single = ~conflict;
  wire logic tsel_ok = (trim_sel_q >= 32'h1) && (trim_sel_q <= 32'(TRIM_PRESETS));
  wire logic fsel_ok = (filt_sel_q >= 32'h1) && (filt_sel_q <= 32'(FILT_PRESETS));
  wire logic [3:0] tidx = 4'(trim_sel_q - 32'h1);
  wire logic save_go = s_save & single & tsel_ok;
  wire logic rcl_load = s_rtrim & single & tsel_ok;
  wire logic rcl_clear = s_rtrim & single & ~rtrim_prev_q & ~tsel_ok;
  wire logic fl_go = s_rfilt & single & fsel_ok;
  wire logic fl_clear = s_rfilt & single & ~rfilt_prev_q & ~fsel_ok;

  // filter config path
  wire logic cfg_ok = cfg_addr_q < 7'(FILT_WORDS);
  wire logic cfg_wr = wr_go & (widx == IDX_CFG_DATA) & cfg_ok;
  wire logic [6:0] fmem_idx = 7'(7'(7'(filt_app_q - 3'h1) * 7'(FILT_SET_WORDS)) + 7'(filt_idx));
  wire logic fmem_ok = (filt_app_q != 3'h0) && (filt_idx < 5'(FILT_SET_WORDS));

  // read selection
  wire logic [GW-1:0] rd_gin = gain_in_q[gidx*GW +: GW];
  wire logic [GW-1:0] rd_gfb = gain_app_q[fbidx*GW +: GW];
  wire logic [31:0] rd_status = 32'({conflict, 1'b0, filt_app_q}) << ST_FILT_LSB;
  wire logic [31:0] rd_ctrl =
    (widx == IDX_TRIM_SEL) ? trim_sel_q :
    (widx == IDX_FILT_SEL) ? filt_sel_q :
    (widx == IDX_STROBE) ? {29'h0, strobe_q} :
    (widx == IDX_STATUS) ? rd_status :
    (widx == IDX_CFG_ADDR) ? {25'h0, cfg_addr_q} :
    (widx == IDX_CFG_DATA && cfg_ok) ? filt_mem[cfg_addr_q] : 32'h0;
  wire logic [31:0] rd_mux =
    in_gain ? {{(32-GW){rd_gin[GW-1]}}, rd_gin} :
    in_fb ? {{(32-GW){rd_gfb[GW-1]}}, rd_gfb} : rd_ctrl;

  // bus handshake: one wait cycle, then completion
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waitrequest_q <= 1'b1;
      readdata_q <= 32'h0;
    end
    else
    begin
      waitrequest_q <= ~req_take;
      if (req_take && avs_read)
        readdata_q <= rd_mux;
    end
  end

  // control registers, selectors keep any written value
  wire logic tsel_wr = wr_go & (widx == IDX_TRIM_SEL);
  wire logic fsel_wr = wr_go & (widx == IDX_FILT_SEL);
  wire logic stb_wr = wr_go & (widx == IDX_STROBE);
  wire logic caddr_wr = wr_go & (widx == IDX_CFG_ADDR);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      trim_sel_q <= SEL_RST;
    else if (tsel_wr)
      trim_sel_q <= avs_writedata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      filt_sel_q <= SEL_RST;
    else if (fsel_wr)
      filt_sel_q <= avs_writedata;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      strobe_q <= STROBE_RST;
    else if (stb_wr)
      strobe_q <= avs_writedata[2:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_addr_q <= 7'h0;
    else if (caddr_wr)
      cfg_addr_q <= avs_writedata[6:0];
  end

  // band gain inputs, clipped on write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      gain_in_q <= '0;
    else if (gain_wr)
      gain_in_q[gidx*GW +: GW] <= gain_clip_val;
  end

  // applied gains: recall overrides, writes update one band
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      gain_app_q <= '0;
    else if (rcl_load)
      gain_app_q <= trim_mem[tidx];
    else if (rcl_clear)
      gain_app_q <= '0;
    else if (gain_wr && !(s_rtrim && !single))
      gain_app_q[gidx*GW +: GW] <= gain_clip_val;
  end

  // trim preset store
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < TRIM_PRESETS; i++)
        trim_mem[i] <= '0;
    end
    else if (save_go)
      trim_mem[tidx] <= gain_in_q;
  end

  // filter preset store, loaded only over the config window
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < FILT_WORDS; i++)
        filt_mem[i] <= 32'h0;
    end
    else if (cfg_wr)
      filt_mem[cfg_addr_q] <= avs_writedata;
  end

  // filter recall and edge history
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      filt_app_q <= 3'h0;
      rtrim_prev_q <= 1'b0;
      rfilt_prev_q <= 1'b0;
      filt_word_q <= 32'h0;
    end
    else
    begin
      rtrim_prev_q <= s_rtrim;
      rfilt_prev_q <= s_rfilt;
      if (fl_go)
        filt_app_q <= filt_sel_q[2:0];
      else if (fl_clear)
        filt_app_q <= 3'h0;
      filt_word_q <= fmem_ok ? filt_mem[fmem_idx] : 32'h0;
    end
  end

  // outputs
  assign avs_waitrequest = waitrequest_q;
  assign avs_readdata = readdata_q;
  assign left_band_gain_fb = gain_app_q[0 +: NBAND*GW];
  assign right_band_gain_fb = gain_app_q[NBAND*GW +: NBAND*GW];
  assign speech_band_gain_fb = gain_app_q[2*NBAND*GW +: NBAND*GW];
  assign filt_word = filt_word_q;
  assign filt_preset = filt_app_q;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence req_s;
    (avs_read | avs_write) & waitrequest_q;
  endsequence
  sequence done_s;
    !waitrequest_q ##1 waitrequest_q;
  endsequence
  sequence filt_off_s;
    filt_app_q == 3'h0 ##1 filt_word_q == 32'h0;
  endsequence

  bus_answer_a: assert property (req_s |=> done_s)
    else $error("slave did not answer after one wait cycle");

  clip_range_a: assert property (gain_wr |-> ($signed(gain_clip_val) <= 8'sd120 &&
    $signed(gain_clip_val) >= -8'sd120))
    else $error("written gain not saturated");

  clip_hi_a: assert property (gain_wr && $signed(avs_writedata) > 32'sd120
    |=> gain_in_q[$past(gidx)*GW +: GW] == 8'd120)
    else $error("large gain not clipped to top limit");

  save_store_a: assert property (save_go |=> trim_mem[$past(tidx)] == $past(gain_in_q))
    else $error("save did not store current gains");

  bad_save_a: assert property (s_save && !tsel_ok |=> $stable(gain_app_q) || $past(gain_wr))
    else $error("invalid trim selector changed state");

  recall_load_a: assert property (rcl_load |=> gain_app_q == $past(trim_mem[tidx]))
    else $error("recall did not apply preset");

  recall_clear_a: assert property (s_rtrim && !rtrim_prev_q && single && !tsel_ok
    |=> gain_app_q == '0)
    else $error("invalid recall did not clear gains");

  filt_apply_a: assert property (fl_go |=> filt_app_q == $past(filt_sel_q[2:0])
    && filt_app_q >= 3'h1 && filt_app_q <= 3'h5)
    else $error("filter recall not applied");

  filt_clear_a: assert property (fl_clear |=> filt_off_s)
    else $error("invalid filter recall did not clear");

  conflict_hold_a: assert property (conflict && !gain_wr |=> $stable(gain_app_q)
    && $stable(filt_app_q))
    else $error("conflicting strobes changed applied values");

  gain_write_a: assert property (gain_wr && !s_rtrim
    |=> gain_app_q[$past(gidx)*GW +: GW] == $past(gain_clip_val))
    else $error("band write not applied");

  clip_lo_a: assert property (gain_wr && $signed(avs_writedata) < -32'sd120
    |=> gain_in_q[$past(gidx)*GW +: GW] == 8'h88)
    else $error("small gain not clipped to bottom limit");

  clip_pass_a: assert property (gain_wr && $signed(avs_writedata) <= 32'sd120
    && $signed(avs_writedata) >= -32'sd120 |=> gain_in_q[$past(gidx)*GW +: GW] == $past(avs_writedata[7:0]))
    else $error("in-range gain altered");

  bad_recall_a: assert property (s_rtrim && single && rtrim_prev_q && !tsel_ok
    |=> $stable(gain_app_q) || $past(gain_wr))
    else $error("held recall with invalid selector changed gains");

  bad_filt_a: assert property (s_rfilt && single && rfilt_prev_q && !fsel_ok |=> $stable(filt_app_q))
    else $error("held filter recall with invalid selector changed preset");

  cfg_store_a: assert property (cfg_wr |=> filt_mem[$past(cfg_addr_q)] == $past(avs_writedata))
    else $error("filter config word not stored");

  filt_range_a: assert property (filt_app_q <= 3'h5)
    else $error("applied filter preset out of range");

  filt_word_a: assert property (!fmem_ok |=> filt_word_q == 32'h0)
    else $error("filter word shown with no applied preset");

  save_block_a: assert property (conflict && tsel_ok |=> trim_mem[$past(tidx)] == $past(trim_mem[tidx]))
    else $error("conflicting strobes changed a preset");

  rd_extend_a: assert property (req_take && avs_read && (in_gain || in_fb)
    |=> readdata_q[31:GW] == {(32-GW){readdata_q[GW-1]}})
    else $error("gain read not sign extended");

endmodule : eq_trim_filter_preset_ctrl
`default_nettype wire

//--- tb/ctrl_prog_model.sv
// control program model: avalon-mm master for the preset controller
// assumes a slave that lowers waitrequest once per request
`timescale 1ns/1ns
`default_nettype none
module ctrl_prog_model (
  // clock
  input wire logic clk,
  // avalon-mm master
  output logic [eq_pkg::ADDR_W-1:0] address,
  output logic read,
  output logic write,
  output logic [3:0] byteenable,
  output logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  import eq_pkg::*;
  initial
  begin
    address = 9'h000;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'hF;
    writedata = 32'h0000_0000;
  end
  // one access; released address and data lines show inverted values
  task automatic xfer(input logic rd, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= rd;
    write <= !rd;
    @(posedge clk);
    while (waitrequest !== 1'b0)
      @(posedge clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    address <= ~a;
    writedata <= ~d;
  endtask : xfer
endmodule : ctrl_prog_model
`default_nettype wire

//--- tb/tb_top.sv
// bench for the trim and filter preset controller
// assumes the control program model as bus master, 250 MHz clock
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import eq_pkg::*;
  localparam logic [8:0] A_TSEL = {IDX_TRIM_SEL, 2'b00};
  localparam logic [8:0] A_FSEL = {IDX_FILT_SEL, 2'b00};
  localparam logic [8:0] A_STB = {IDX_STROBE, 2'b00};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [8:0] address;
  logic read, write, waitrequest;
  logic [3:0] byteenable;
  logic [31:0] writedata, readdata, rd_q, filt_word;
  logic [79:0] fb_l, fb_r, fb_s;
  logic [4:0] filt_idx = 5'h00;
  logic [2:0] filt_preset;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  ctrl_prog_model ctrl_prog_model_i (.clk(clk), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
  eq_trim_filter_preset_ctrl eq_trim_filter_preset_ctrl_i (.clk(clk), .reset_n(reset_n),
    .avs_address(address), .avs_read(read), .avs_write(write), .avs_byteenable(byteenable),
    .avs_writedata(writedata), .avs_readdata(readdata), .avs_waitrequest(waitrequest),
    .left_band_gain_fb(fb_l), .right_band_gain_fb(fb_r), .speech_band_gain_fb(fb_s),
    .filt_idx(filt_idx), .filt_word(filt_word), .filt_preset(filt_preset));
  task automatic report_and_stop;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_g(input logic [79:0] fb, input int b, input logic [7:0] exp);
    chk({24'h000000, fb[b*8 +: 8]}, {24'h000000, exp});
  endtask : chk_g
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    ctrl_prog_model_i.xfer(1'b0, a, d, rd_q);
  endtask : wr
  task automatic rd(input logic [8:0] a);
    ctrl_prog_model_i.xfer(1'b1, a, 32'h0000_0000, rd_q);
  endtask : rd
  task automatic wg(input int idx, input logic [31:0] d);
    wr({7'(idx), 2'b00}, d);
  endtask : wg
  task automatic t_clip;
    wg(0, 32'h0000_00C8);
    wg(19, 32'hFFFF_FED4);
    wg(23, 32'h0000_0005);
    repeat (2) @(posedge clk);
    chk_g(fb_l, 0, 8'(GAIN_MAX));
    chk_g(fb_r, 9, 8'(GAIN_MIN));
    chk_g(fb_s, 3, 8'h05);
    chk_g(fb_s, 0, 8'h00);
    rd({IDX_GAIN_FB + 7'h13, 2'b00});
    chk(rd_q, 32'hFFFF_FF88);
    rd(9'h1FC);
    chk(rd_q, 32'h0000_0000);
    $display("clip test done");
  endtask : t_clip
  task automatic t_preset;
    wr(A_TSEL, 32'h0000_000A);
    wr(A_STB, 32'h0000_0001);
    wr(A_STB, 32'h0000_0000);
    wg(0, 32'h0000_0000);
    wr(A_STB, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk_g(fb_l, 0, 8'(GAIN_MAX));
    chk_g(fb_r, 9, 8'(GAIN_MIN));
    wr(A_STB, 32'h0000_0000);
    $display("preset test done");
  endtask : t_preset
  task automatic t_conflict;
    wg(0, 32'h0000_0007);
    wr(A_STB, 32'h0000_0003);
    repeat (2) @(posedge clk);
    chk_g(fb_l, 0, 8'h07);
    rd({IDX_STATUS, 2'b00});
    chk({31'h0, rd_q[ST_CONFLICT]}, 32'h0000_0001);
    wr(A_STB, 32'h0000_0000);
    wr(A_STB, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk_g(fb_l, 0, 8'(GAIN_MAX));
    wr(A_STB, 32'h0000_0000);
    $display("conflict test done");
  endtask : t_conflict
  task automatic t_bad_trim;
    wr(A_TSEL, 32'h0000_000B);
    wg(0, 32'h0000_0030);
    wr(A_STB, 32'h0000_0001);
    wr(A_STB, 32'h0000_0000);
    chk_g(fb_l, 0, 8'h30);
    wr(A_STB, 32'h0000_0002);
    repeat (2) @(posedge clk);
    for (int b = 0; b < NBAND; b++)
    begin
      chk_g(fb_l, b, 8'h00);
      chk_g(fb_r, b, 8'h00);
      chk_g(fb_s, b, 8'h00);
    end
    wr(A_STB, 32'h0000_0000);
    wr(A_TSEL, 32'h0000_000A);
    wr(A_STB, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk_g(fb_l, 0, 8'(GAIN_MAX));
    chk_g(fb_s, 3, 8'h05);
    wr(A_STB, 32'h0000_0000);
    $display("bad trim test done");
  endtask : t_bad_trim
  function automatic logic [31:0] fw(input int t);
    return {3'(t), 5'h04, 8'h0A, 16'(t * 1000)};
  endfunction : fw
  task automatic recall_filt(input logic [31:0] sel, input logic [2:0] exp_p);
    wr(A_FSEL, sel);
    wr(A_STB, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk({29'h0, filt_preset}, {29'h0, exp_p});
    wr(A_STB, 32'h0000_0000);
  endtask : recall_filt
  task automatic t_filter;
    for (int t = 1; t <= 5; t++)
    begin
      wr({IDX_CFG_ADDR, 2'b00}, 32'(t - 1));
      wr({IDX_CFG_DATA, 2'b00}, fw(t));
    end
    wr({IDX_CFG_ADDR, 2'b00}, 32'd72);
    wr({IDX_CFG_DATA, 2'b00}, fw(6));
    recall_filt(32'h0000_0001, 3'h1);
    for (int t = 1; t <= 5; t++)
    begin
      @(posedge clk);
      filt_idx <= 5'(t - 1);
      repeat (2) @(posedge clk);
      chk(filt_word, fw(t));
    end
    @(posedge clk);
    filt_idx <= 5'h00;
    recall_filt(32'h0000_0005, 3'h5);
    chk(filt_word, fw(6));
    recall_filt(32'h0000_0006, 3'h0);
    chk(filt_word, 32'h0000_0000);
    $display("filter test done");
  endtask : t_filter
  initial
  begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_clip();
    t_preset();
    t_conflict();
    t_bad_trim();
    t_filter();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
